/* rtl/spi_status_pkg.sv */
package spi_status_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RW_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 9;
  localparam int PARITY_POS = 8;
  localparam logic [5:0] ADDR_LAST = 6'h0c;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_FAULT_SUMMARY = 6'h00;
  localparam logic [5:0] OFS_DRIVER_DETAIL = 6'h01;
  localparam logic [5:0] OFS_SUPPLY_LINK = 6'h02;
  localparam logic [5:0] OFS_CONTROL_FIRST = 6'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SUM_FAULT = 0;
  localparam int SUM_OVERTEMP = 1;
  localparam int SUM_OVERVOLT = 2;
  localparam int SUM_POR_BAR = 3;
  localparam int SUM_OVERCUR = 4;
  localparam int SUM_SERIAL = 5;
  localparam int SUM_BUCK = 6;
  localparam int S2_ADDR_ERR = 0;
  localparam int S2_FRAME_ERR = 1;
  localparam int S2_PARITY_ERR = 2;
  localparam int CTRL_CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int RESET_WINDOW_US = 20;
  localparam int RESET_WINDOW_CYC = RESET_WINDOW_US * CLK_MHZ;

endpackage

/* rtl/sync_two.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_two #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] first_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      first_reg <= '0;
      sync_out <= '0;
    end else begin
      first_reg <= async_in;
      sync_out <= first_reg;
    end
  end
endmodule
`default_nettype wire

/* rtl/motor_driver_spi_status_port.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_driver_spi_status_port
  import spi_status_pkg::*;
#(
  parameter int RESET_WINDOW = RESET_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic chip_select_bar,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic sleep_bar_pin,
  input wire logic driver_disable_pin,
  input wire logic [2:0] high_side_input,
  input wire logic [2:0] low_side_input,
  input wire logic overtemp_flag,
  input wire logic overvoltage_flag,
  input wire logic overcurrent_flag,
  input wire logic buck_fault,
  input wire logic supply_por_bar,
  input wire logic [7:0] driver_detail_in,
  input wire logic [4:0] supply_detail_in,
  output logic [2:0] high_side_gate,
  output logic [2:0] low_side_gate,
  output logic fault_out_bar,
  output logic shutdown_req
);

  typedef struct packed {
    logic sclk_d;
    logic csb_d;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [4:0] bit_count;
    logic overrun;
    logic sdo;
    logic sdo_en;
    logic [9:0][7:0] ctrl;
    logic frame_error;
    logic bad_address_error;
    logic parity_error;
    logic drv_latched;
    logic sleep_d;
    logic asleep;
    logic [31:0] low_count;
    logic [2:0] hs;
    logic [2:0] ls;
    logic fault_bar;
    logic shut;
  } state_t;

  state_t cur_reg, cur_next;
  logic [4:0] pins_s;
  logic sclk_s, sdi_s, csb_s, sleep_s, doff_s;
  logic cs_sel_s, sleep_req_s;
  logic [7:0] summary_v, status_two_reg, detail_v;
  logic serial_fault_summary;
  logic driver_fault_live;
  logic [7:0] reg_data [0:15];

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  sync_two #(.W(5)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({serial_clk, serial_in, ~chip_select_bar, ~sleep_bar_pin,
               driver_disable_pin}),
    .sync_out(pins_s)
  );
  // Select and sleep pass inverted, so the cleared synchroniser reads as
  // deselected and awake and no false edge follows reset.
  assign {sclk_s, sdi_s, cs_sel_s, sleep_req_s, doff_s} = pins_s;
  assign csb_s = ~cs_sel_s;
  assign sleep_s = ~sleep_req_s;

  // ----------------------------------------------------------------
  // Status view.
  // ----------------------------------------------------------------
  assign driver_fault_live = overcurrent_flag & ~doff_s;
  assign serial_fault_summary = cur_reg.frame_error |
                                cur_reg.bad_address_error |
                                cur_reg.parity_error;
  assign status_two_reg = {1'b0, supply_detail_in[3:0],
                           cur_reg.parity_error, cur_reg.frame_error,
                           cur_reg.bad_address_error};
  assign detail_v = driver_detail_in;
  always_comb begin
    summary_v = 8'h00;
    summary_v[SUM_OVERTEMP] = overtemp_flag;
    summary_v[SUM_OVERVOLT] = overvoltage_flag;
    summary_v[SUM_POR_BAR] = supply_por_bar;
    summary_v[SUM_OVERCUR] = driver_fault_live | cur_reg.drv_latched;
    summary_v[SUM_SERIAL] = serial_fault_summary;
    summary_v[SUM_BUCK] = buck_fault;
    summary_v[SUM_FAULT] = overtemp_flag | overvoltage_flag |
                           summary_v[SUM_OVERCUR] | buck_fault |
                           serial_fault_summary;
  end

  generate
    for (genvar i = 0; i < 16; i++) begin : g_map
      if (i == 0) begin : g_sum
        assign reg_data[i] = summary_v;
      end else if (i == 1) begin : g_det
        assign reg_data[i] = detail_v;
      end else if (i == 2) begin : g_st2
        assign reg_data[i] = status_two_reg;
      end else if (i >= 3 && i <= 12) begin : g_ctl
        assign reg_data[i] = cur_reg.ctrl[i-3];
      end else begin : g_none
        assign reg_data[i] = RESET_BYTE;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, frame_ok, clr;
    logic [15:0] word;
    logic [5:0] addr;
    logic [7:0] old;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    frame_ok = 1'b0;
    clr = 1'b0;
    word = 16'h0000;
    addr = 6'h00;
    old = 8'h00;
    cur_next = cur_reg;
    cur_next.sclk_d = sclk_s;
    cur_next.csb_d = csb_s;
    cur_next.sleep_d = sleep_s;
    sclk_rise = sclk_s & ~cur_reg.sclk_d;
    sclk_fall = ~sclk_s & cur_reg.sclk_d;
    cs_fall = ~csb_s & cur_reg.csb_d;
    cs_rise = csb_s & ~cur_reg.csb_d;

    if (cs_fall) begin
      cur_next.bit_count = 5'h00;
      cur_next.overrun = 1'b0;
      cur_next.sdo_en = 1'b1;
      cur_next.shift_out = {summary_v, 8'h00};
      cur_next.sdo = summary_v[7];
    end else if (!csb_s && !cur_reg.csb_d) begin
      if (sclk_fall) begin
        cur_next.shift_in = {cur_reg.shift_in[14:0], sdi_s};
        if (cur_reg.bit_count == 5'(FRAME_BITS)) begin
          cur_next.overrun = 1'b1;
        end else begin
          cur_next.bit_count = cur_reg.bit_count + 5'h01;
        end
        if (cur_reg.bit_count == 5'h07) begin
          addr = {cur_reg.shift_in[5:0]};
          // Seven shifts have passed, so the data byte sits at bits 14..7.
          cur_next.shift_out[14:7] = reg_data[addr[3:0]];
          if (addr > ADDR_LAST) begin
            cur_next.shift_out[14:7] = RESET_BYTE;
          end
        end
      end
      if (sclk_rise && cur_reg.bit_count != 5'h00) begin
        cur_next.shift_out = {cur_reg.shift_out[14:0], 1'b0};
        cur_next.sdo = cur_reg.shift_out[14];
      end
    end

    if (cs_rise) begin
      cur_next.sdo_en = 1'b0;
      frame_ok = (cur_reg.bit_count == 5'(FRAME_BITS)) & ~cur_reg.overrun;
      word = cur_reg.shift_in;
      addr = word[ADDR_HI:ADDR_LO];
      if (!frame_ok) begin
        cur_next.frame_error = 1'b1;
      end else if (^word) begin
        cur_next.parity_error = 1'b1;
      end else if (addr > ADDR_LAST) begin
        cur_next.bad_address_error = 1'b1;
      end else if (!word[RW_POS] &&
                   addr >= OFS_CONTROL_FIRST) begin
        cur_next.ctrl[addr - OFS_CONTROL_FIRST] = word[7:0];
        clr = (addr == OFS_CONTROL_FIRST) & word[CTRL_CLEAR_BIT];
      end
    end

    // Sleep-pin low phase timing.
    if (!sleep_s) begin
      if (cur_reg.low_count < 32'(RESET_WINDOW)) begin
        cur_next.low_count = cur_reg.low_count + 32'h1;
      end else begin
        cur_next.asleep = 1'b1;
      end
    end else begin
      cur_next.low_count = 32'h0;
      if (!cur_reg.sleep_d && !cur_reg.asleep) begin
        clr = 1'b1;
      end
      cur_next.asleep = 1'b0;
    end

    if (clr) begin
      cur_next.frame_error = 1'b0;
      cur_next.bad_address_error = 1'b0;
      cur_next.parity_error = 1'b0;
      cur_next.drv_latched = 1'b0;
      cur_next.ctrl[0][CTRL_CLEAR_BIT] = 1'b0;
    end
    if (driver_fault_live) begin
      cur_next.drv_latched = 1'b1;
    end
    // Error sets are applied again after the clear, so that a set wins.
    if (cs_rise && !frame_ok) begin
      cur_next.frame_error = 1'b1;
    end
    if (cs_rise && frame_ok && (^word)) begin
      cur_next.parity_error = 1'b1;
    end
    if (cs_rise && frame_ok && !(^word) && addr > ADDR_LAST) begin
      cur_next.bad_address_error = 1'b1;
    end

    if (cur_reg.asleep) begin
      for (int k = 0; k < 10; k++) begin
        cur_next.ctrl[k] = RESET_BYTE;
      end
      cur_next.frame_error = 1'b0;
      cur_next.bad_address_error = 1'b0;
      cur_next.parity_error = 1'b0;
      cur_next.drv_latched = 1'b0;
      cur_next.sdo_en = 1'b0;
    end

    cur_next.shut = cur_reg.asleep;
    if (doff_s || cur_reg.drv_latched || cur_reg.asleep) begin
      cur_next.hs = 3'h0;
      cur_next.ls = 3'h0;
    end else begin
      cur_next.hs = high_side_input;
      cur_next.ls = low_side_input;
    end
    cur_next.fault_bar = ~summary_v[SUM_FAULT];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_reg <= '0;
      cur_reg.csb_d <= 1'b1;
      cur_reg.sleep_d <= 1'b1;
      cur_reg.fault_bar <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign serial_out = cur_reg.sdo;
  assign serial_out_en = cur_reg.sdo_en;
  assign high_side_gate = cur_reg.hs;
  assign low_side_gate = cur_reg.ls;
  assign fault_out_bar = cur_reg.fault_bar;
  assign shutdown_req = cur_reg.shut;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  frame_err_a: assert property (@(posedge clk) disable iff (reset)
    ($rose(csb_s) && !cur_reg.asleep &&
     (cur_reg.bit_count != 5'h10 || cur_reg.overrun))
      |=> cur_reg.frame_error)
    else $error("bad frame length did not set frame error");
  hiz_a: assert property (@(posedge clk) disable iff (reset)
    (csb_s && $past(csb_s)) |=> !cur_reg.sdo_en)
    else $error("data-out driven while deselected");
  gate_off_a: assert property (@(posedge clk) disable iff (reset)
    doff_s |=> (cur_reg.hs == 3'h0 && cur_reg.ls == 3'h0))
    else $error("gates on while driver disabled");
  serial_sum_a: assert property (@(posedge clk) disable iff (reset)
    serial_fault_summary |=> !fault_out_bar)
    else $error("serial fault not reported as a fault");
  por_bit_a: assert property (@(posedge clk) disable iff (reset)
    $fell(csb_s)
      |=> cur_reg.shift_out[8 + SUM_POR_BAR] == $past(supply_por_bar))
    else $error("power-on bit wrong");
  sleep_clear_a: assert property (@(posedge clk) disable iff (reset)
    cur_reg.asleep |=> !cur_reg.frame_error && cur_reg.ctrl[0] == 8'h00)
    else $error("registers not reset in sleep");
  status_two_a: assert property (@(posedge clk) disable iff (reset)
    $rose(cur_reg.parity_error)
      |-> $past(csb_s && !cur_reg.csb_d && (^cur_reg.shift_in)))
    else $error("parity error set without an odd frame");
  first_bit_a: assert property (@(posedge clk) disable iff (reset)
    $fell(csb_s) |=> cur_reg.sdo == $past(summary_v[7]))
    else $error("status msb not first");
  no_write_a: assert property (@(posedge clk) disable iff (reset)
    (csb_s && !cur_reg.csb_d && !cur_reg.asleep &&
     !(sleep_s && !cur_reg.sleep_d) &&
     (cur_reg.bit_count != 5'h10 || cur_reg.overrun ||
      (^cur_reg.shift_in) || cur_reg.shift_in[RW_POS] ||
      cur_reg.shift_in[ADDR_HI:ADDR_LO] > ADDR_LAST))
      |=> cur_reg.ctrl == $past(cur_reg.ctrl))
    else $error("rejected or read frame changed a register");
  sleep_window_a: assert property (@(posedge clk) disable iff (reset)
    (!sleep_s && cur_reg.low_count >= 32'(RESET_WINDOW)) |=> cur_reg.asleep)
    else $error("long sleep low phase did not shut down");
  frame_cov: cover property (@(posedge clk) $rose(csb_s) &&
    cur_reg.bit_count == 5'h10);
  write_cov: cover property (@(posedge clk) cur_reg.ctrl[1] != 8'h00);
  pulse_cov: cover property (@(posedge clk) $rose(sleep_s));
  parity_cov: cover property (@(posedge clk) $rose(cur_reg.parity_error));
  shut_cov: cover property (@(posedge clk) $rose(cur_reg.asleep));
endmodule
`default_nettype wire

/* sim/spi_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_model (
  output logic serial_clk,
  output logic serial_in,
  output logic chip_select_bar,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  // ----------------------------------------------------------------
  // Serial controller
  // ----------------------------------------------------------------
  initial begin
    serial_clk = 1'h0;
    serial_in = 1'h0;
    chip_select_bar = 1'h1;
  end

  // Sends n clocks of w, MSB first, and gathers the first sixteen reply bits.
  task automatic xfer(input logic [15:0] w, input int n,
      output logic [15:0] r);
    r = 16'h0000;
    chip_select_bar = 1'h0;
    #80;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'h1;
      serial_in = (i < 16) ? w[15 - i] : 1'h0;
      #80;
      serial_clk = 1'h0;
      if (i < 16) begin
        r[15 - i] = serial_out_en ? serial_out : 1'hz;
      end
      #80;
    end
    chip_select_bar = 1'h1;
    serial_in = ~serial_in;
    #480;
  endtask
endmodule
`default_nettype wire

/* sim/motor_driver_spi_status_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_driver_spi_status_port_tb;
  import spi_status_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] st;
    logic [7:0] dat;
  } row_t;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic serial_clk, serial_in, chip_select_bar, serial_out, serial_out_en;
  logic sleep_bar_pin = 1'h1;
  logic driver_disable_pin = 1'h0;
  logic ot = 1'h0;
  logic oc = 1'h0;
  logic ov = 1'h0;
  logic bk = 1'h0;
  logic por = 1'h1;
  logic [2:0] hs_gate, ls_gate;
  logic fault_out_bar, shutdown_req;
  logic [15:0] r;
  int num_errors = 0;
  int checks = 0;
  row_t rows [11];

  always #4 clk = ~clk;

  motor_driver_spi_status_port #(.RESET_WINDOW(50)) u_dut (
    .clk(clk), .reset(reset), .serial_clk(serial_clk),
    .serial_in(serial_in), .chip_select_bar(chip_select_bar),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .sleep_bar_pin(sleep_bar_pin), .driver_disable_pin(driver_disable_pin),
    .high_side_input(3'h5), .low_side_input(3'h2),
    .overtemp_flag(ot), .overvoltage_flag(ov), .overcurrent_flag(oc),
    .buck_fault(bk), .supply_por_bar(por),
    .driver_detail_in(8'h3c), .supply_detail_in(5'h00),
    .high_side_gate(hs_gate), .low_side_gate(ls_gate),
    .fault_out_bar(fault_out_bar), .shutdown_req(shutdown_req)
  );

  spi_ctrl_model u_ctrl (
    .serial_clk(serial_clk), .serial_in(serial_in),
    .chip_select_bar(chip_select_bar), .serial_out(serial_out),
    .serial_out_en(serial_out_en)
  );

  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] mk(input logic rw, input logic [5:0] a,
      input logic [7:0] d, input logic bad);
    logic [15:0] w;
    w = {rw, a, 1'h0, d};
    w[PARITY_POS] = (^w) ^ bad;
    return w;
  endfunction

  task automatic cmp8(input string n, input logic [7:0] e,
      input logic [7:0] g, input logic [7:0] m);
    checks++;
    if ((g & m) !== (e & m)) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e & m, g & m);
    end
  endtask

  task automatic frame(input logic [15:0] w, input int n,
      input logic [7:0] st, input logic [7:0] d, input logic [7:0] m);
    // Starting on the falling clock keeps pin changes off the sampling edge.
    @(negedge clk);
    u_ctrl.xfer(w, n, r);
    cmp8("status", st, r[15:8], m);
    if (n == 16) begin
      cmp8("data", d, r[7:0], 8'hff);
    end
    cmp8("sdo_en", 8'h00, {7'h0, serial_out_en}, 8'hff);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    rows[0] = {mk(1'h0, 6'h04, 8'h5a, 1'h0), 8'h00, 8'h00};
    rows[1] = {mk(1'h1, 6'h04, 8'h00, 1'h0), 8'h00, 8'h5a};
    rows[2] = {mk(1'h0, 6'h01, 8'hff, 1'h0), 8'h00, 8'h3c};
    rows[3] = {mk(1'h1, 6'h01, 8'h00, 1'h0), 8'h00, 8'h3c};
    rows[4] = {mk(1'h1, 6'h0d, 8'h00, 1'h0), 8'h00, 8'h00};
    rows[5] = {mk(1'h1, 6'h02, 8'h00, 1'h0), 8'h20, 8'h01};
    rows[6] = {mk(1'h0, 6'h04, 8'h77, 1'h1), 8'h20, 8'h5a};
    rows[7] = {mk(1'h1, 6'h04, 8'h00, 1'h0), 8'h20, 8'h5a};
    rows[8] = {mk(1'h1, 6'h02, 8'h00, 1'h0), 8'h20, 8'h05};
    rows[9] = {mk(1'h0, 6'h03, 8'h01, 1'h0), 8'h20, 8'h00};
    rows[10] = {mk(1'h1, 6'h02, 8'h00, 1'h0), 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    cmp8("fault_out_bar", 8'h01, {7'h0, fault_out_bar}, 8'hff);
    reset <= 1'h0;
    repeat (8) @(posedge clk);
    foreach (rows[i]) begin
      frame(rows[i].word, 16, rows[i].st, rows[i].dat, 8'hf6);
    end
    frame(mk(1'h1, 6'h04, 8'h00, 1'h0), 15, 8'h00, 8'h00, 8'hf6);
    frame(mk(1'h1, 6'h02, 8'h00, 1'h0), 16, 8'h20, 8'h02, 8'hf6);
    frame(mk(1'h0, 6'h04, 8'h11, 1'h0), 17, 8'h20, 8'h00, 8'hf6);
    frame(mk(1'h1, 6'h04, 8'h00, 1'h0), 16, 8'h20, 8'h5a, 8'hf6);
    @(posedge clk);
    sleep_bar_pin <= 1'h0;
    repeat (10) @(posedge clk);
    sleep_bar_pin <= 1'h1;
    repeat (20) @(posedge clk);
    frame(mk(1'h1, 6'h02, 8'h00, 1'h0), 16, 8'h00, 8'h00, 8'hf6);
    frame(mk(1'h1, 6'h04, 8'h00, 1'h0), 16, 8'h00, 8'h5a, 8'hf6);
    @(posedge clk);
    sleep_bar_pin <= 1'h0;
    repeat (100) @(posedge clk);
    cmp8("shutdown_req", 8'h01, {7'h0, shutdown_req}, 8'hff);
    sleep_bar_pin <= 1'h1;
    repeat (20) @(posedge clk);
    frame(mk(1'h1, 6'h04, 8'h00, 1'h0), 16, 8'h00, 8'h00, 8'hf6);
    @(posedge clk);
    cmp8("gates", 8'h2a, {2'h0, hs_gate, ls_gate}, 8'hff);
    driver_disable_pin <= 1'h1;
    repeat (8) @(posedge clk);
    cmp8("gates", 8'h00, {2'h0, hs_gate, ls_gate}, 8'hff);
    frame(mk(1'h0, 6'h04, 8'h33, 1'h0), 16, 8'h00, 8'h00, 8'hf6);
    @(posedge clk);
    driver_disable_pin <= 1'h0;
    ot <= 1'h1;
    oc <= 1'h1;
    repeat (4) @(posedge clk);
    ot <= 1'h0;
    oc <= 1'h0;
    repeat (8) @(posedge clk);
    cmp8("gates", 8'h00, {2'h0, hs_gate, ls_gate}, 8'hff);
    cmp8("fault_out_bar", 8'h00, {7'h0, fault_out_bar}, 8'hff);
    frame(mk(1'h1, 6'h00, 8'h00, 1'h0), 16, 8'h11, 8'h19, 8'hf7);
    frame(mk(1'h0, 6'h03, 8'h01, 1'h0), 16, 8'h11, 8'h00, 8'hf7);
    frame(mk(1'h1, 6'h00, 8'h00, 1'h0), 16, 8'h00, 8'h08, 8'hf7);
    @(posedge clk);
    cmp8("gates", 8'h2a, {2'h0, hs_gate, ls_gate}, 8'hff);
    cmp8("fault_out_bar", 8'h01, {7'h0, fault_out_bar}, 8'hff);
    ov <= 1'h1;
    bk <= 1'h1;
    por <= 1'h0;
    frame(mk(1'h1, 6'h00, 8'h00, 1'h0), 16, 8'h45, 8'h45, 8'hff);
    @(posedge clk);
    cmp8("fault_out_bar", 8'h00, {7'h0, fault_out_bar}, 8'hff);
    ov <= 1'h0;
    bk <= 1'h0;
    por <= 1'h1;
    summarize();
  end
endmodule
`default_nettype wire
